// >>> src/serial_port_zero_regs.vh
`ifndef SERIAL_PORT_ZERO_REGS_VH
`define SERIAL_PORT_ZERO_REGS_VH

// Register indices (byte address is four times the index)
`define IDX_PORT_CONTROL     8'h98
`define IDX_PORT_DATA_BUFFER 8'h99
`define IDX_OWN_SLAVE_ADDR   8'ha9
`define IDX_ADDRESS_MASK     8'hb9
`define IDX_POWER_CONTROL    8'h87

// Control register fields
`define CTL_MODE_HI   7
`define CTL_MODE_LO   6
`define CTL_FILTER    5
`define CTL_RX_EN     4
`define CTL_TX9       3
`define CTL_RX9       2
`define CTL_TX_DONE   1
`define CTL_RX_DONE   0

// Power control fields
`define PWR_FE_SEL    6
`define PWR_M2_FAST   7

// Reset values
`define RST_BYTE      8'h00

// Clock dividers, in system clocks per bit
`define DIV_M0_SLOW   12'd12
`define DIV_M0_FAST   12'd4
`define DIV_M2_SLOW   12'd64
`define DIV_M2_FAST   12'd32

// Mode codes
`define MODE_SYNC     2'b00
`define MODE_ASYNC10  2'b01
`define MODE_FIXED11  2'b10
`define MODE_ASYNC11  2'b11

`endif

// >>> src/bit_rate_gen.v
`timescale 1ns/100ps
// Bit tick generator: one pulse every div_i enabled clocks
module bit_rate_gen #(
	parameter WIDTH = 12
) (
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             ce_i,
	input  wire             restart_i,
	input  wire [WIDTH-1:0] div_i,
	output reg              tick_o
);
	reg [WIDTH-1:0] cnt_q;

	// Restart keeps frame bit cells aligned to the start event
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q  <= {WIDTH{1'b0}};
			tick_o <= 1'b0;
		end else if (ce_i) begin
			if (restart_i || cnt_q >= div_i - {{(WIDTH-1){1'b0}}, 1'b1}) begin
				cnt_q  <= {WIDTH{1'b0}};
				tick_o <= ~restart_i;
			end else begin
				cnt_q  <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
				tick_o <= 1'b0;
			end
		end else begin
			tick_o <= 1'b0;
		end
	end
endmodule

// >>> src/serial_port_zero.v
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
`include "serial_port_zero_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Top bit: mode high or framing error
// - Two mode bits select four frame modes
// - Modes 2/3 filter: ninth bit zero suppressed
// - Mode 1 filter: need valid stop bit
// - Mode 0 clock divides by 12 or 4
// - Receive only while receive enable set
// - Modes 2/3 send software ninth bit
// - Capture ninth bit or stop bit
// - Transmit done timing, software clears
// - Receive done timing, software clears
// - Data buffer: read receive, write transmit
// - Slave address used for recognition
// - Masked compare; zero mask matches all
module serial_port_zero #(
	parameter DIV_WIDTH = 12
) (
	// System
	input  wire           CLK_I,
	input  wire           SRST_I,
	input  wire           CE_I,
	// Wishbone slave
	input  wire           CYC_I,
	input  wire           STB_I,
	input  wire           WE_I,
	input  wire [9:0]     ADR_I,
	input  wire [3:0]     SEL_I,
	input  wire [31:0]    DAT_I,
	output reg  [31:0]    DAT_O,
	output reg            ACK_O,
	output reg            ERR_O,
	// Variable bit rate, clocks per bit for modes 1 and 3
	input  wire [11:0]    RATE_DIV_I,
	// Serial line
	input  wire           RXD_I,
	output reg            RXD_O,
	output reg            RXD_OE_N_O,
	output reg            TXD_O,
	// Interrupt request
	output reg            IRQ_O
);
	////////////////////////////////////////////////////////////////////////////
	// Registers
	reg [7:0]  ctl_q;
	reg [7:0]  tx_buf_q;
	reg [7:0]  rx_buf_q;
	reg [7:0]  own_slave_address_q;
	reg [7:0]  mask_q;
	reg [7:0]  pwr_q;
	reg        fe_q;
	reg        mode_hi_q;
	// With framing errors selected the top control bit reads the flag, while
	// the mode bit it shadows keeps its last written value

	wire       fe_sel = pwr_q[`PWR_FE_SEL];
	wire [1:0] mode   = {mode_hi_q, ctl_q[`CTL_MODE_LO]};
	wire       m0     = (mode == `MODE_SYNC);
	wire       nine   = mode[1];

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	// A request is not taken again while its answer stands, so a master
	// that keeps the strobe up through the ack edge gets one answer only
	wire       req     = CYC_I & STB_I & ~ACK_O & ~ERR_O;
	wire [7:0] idx     = ADR_I[9:2];
	wire       hit_ctl = idx == `IDX_PORT_CONTROL;
	wire       hit_buf = idx == `IDX_PORT_DATA_BUFFER;
	wire       hit_sa  = idx == `IDX_OWN_SLAVE_ADDR;
	wire       hit_msk = idx == `IDX_ADDRESS_MASK;
	wire       hit_pwr = idx == `IDX_POWER_CONTROL;
	wire       mapped  = hit_ctl | hit_buf | hit_sa | hit_msk | hit_pwr;
	wire       wr      = req & mapped & WE_I & SEL_I[0] & CE_I;
	wire       wr_ctl  = wr & hit_ctl;
	wire       wr_buf  = wr & hit_buf;
	// Byte lanes other than lane 0 are ignored; the registers are one byte

	////////////////////////////////////////////////////////////////////////////
	// Bit clock selection
	// The two frame engines share one selected rate but keep their own timers
	reg  [11:0] div;
	// mode 0 rate follows the filter bit; mode 2 rate fixed 64 or 32
	// Limitation: the variable rate must be at least two clocks per bit,
	// or the half-bit start check would sample on the falling edge itself
	always @* begin
		case (mode)
		`MODE_SYNC:    div = ctl_q[`CTL_FILTER] ? `DIV_M0_FAST : `DIV_M0_SLOW;
		`MODE_FIXED11: div = pwr_q[`PWR_M2_FAST] ? `DIV_M2_FAST : `DIV_M2_SLOW;
		default:       div = RATE_DIV_I;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmitter
	localparam TX_IDLE = 3'b001;
	localparam TX_SEND = 3'b010;
	localparam TX_STOP = 3'b100;
	reg  [2:0]  tx_st_q;
	reg  [10:0] tx_sh_q;
	reg  [3:0]  tx_cnt_q;
	reg         tx_set;
	wire        tx_tick;

	bit_rate_gen #(.WIDTH(12)) u_tx_rate (
		.clk_i     (CLK_I),
		.rst_i     (SRST_I),
		.ce_i      (CE_I),
		.restart_i (wr_buf),
		.div_i     (div),
		.tick_o    (tx_tick)
	);

	// Frame is shifted LSB first; async frames carry start, data, ninth in modes 2/3 only, stop
	// The rate counter restarts on the buffer write, so the first bit cell
	// runs one clock longer than the rest; far nodes resync on the start edge
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			tx_st_q  <= TX_IDLE;
			tx_sh_q  <= 11'h7ff;
			tx_cnt_q <= 4'h0;
			tx_set   <= 1'b0;
		end else if (CE_I) begin
			tx_set <= 1'b0;
			if (wr_buf) begin
				tx_st_q <= TX_SEND;
				if (m0) begin
					tx_sh_q  <= {3'h7, DAT_I[7:0]};
					tx_cnt_q <= 4'd8;
				end else if (nine) begin
					tx_sh_q  <= {1'b1, ctl_q[`CTL_TX9], DAT_I[7:0], 1'b0};
					tx_cnt_q <= 4'd10;
				end else begin
					tx_sh_q  <= {2'h3, DAT_I[7:0], 1'b0};
					tx_cnt_q <= 4'd9;
				end
			end else begin
				case (tx_st_q)
				TX_IDLE: tx_sh_q <= 11'h7ff;
				TX_SEND: begin
					if (tx_tick) begin
						tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
						tx_cnt_q <= tx_cnt_q - 4'h1;
						if (tx_cnt_q == 4'h1) begin
							// Mode 0 ends after bit 8; others enter stop bit
							tx_set  <= 1'b1;
							tx_st_q <= m0 ? TX_IDLE : TX_STOP;
						end
					end
				end
				// Stop bit runs a full cell before the line is free again
				TX_STOP: if (tx_tick) tx_st_q <= TX_IDLE;
				default: tx_st_q <= TX_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receiver: mode 0 shifts on own clock; async samples at bit centres
	localparam RX_IDLE  = 4'b0001;
	localparam RX_START = 4'b0010;
	localparam RX_DATA  = 4'b0100;
	localparam RX_STOP  = 4'b1000;
	reg  [3:0]  rx_st_q;
	reg  [8:0]  rx_sh_q;
	reg  [3:0]  rx_cnt_q;
	reg  [11:0] rx_tmr_q;
	reg         rx_prev_q;
	reg         rx_set;
	reg         rx_ninth;
	reg         fe_set;
	wire [11:0] half = {1'b0, div[11:1]};
	wire        addr_ok = ((rx_sh_q[7:0] ^ own_slave_address_q) & mask_q) == 8'h00;
	wire        rx_fall = rx_prev_q & ~RXD_I;

	// Disabling reception drops any frame in progress; the flags and the
	// receive register keep what the last complete frame left there

	always @(posedge CLK_I) begin
		if (SRST_I) begin
			rx_st_q   <= RX_IDLE;
			rx_sh_q   <= 9'h000;
			rx_cnt_q  <= 4'h0;
			rx_tmr_q  <= 12'h000;
			rx_prev_q <= 1'b1;
			rx_set    <= 1'b0;
			rx_ninth  <= 1'b0;
			fe_set    <= 1'b0;
			rx_buf_q  <= `RST_BYTE;
		end else if (CE_I) begin
			rx_prev_q <= RXD_I;
			rx_set    <= 1'b0;
			fe_set    <= 1'b0;
			if (!ctl_q[`CTL_RX_EN]) begin
				rx_st_q <= RX_IDLE;
			end else begin
				case (rx_st_q)
				RX_IDLE: begin
					rx_tmr_q <= 12'h000;
					// Mode 0 waits for software to clear the receive done flag before shifting
					if (m0 && !ctl_q[`CTL_RX_DONE]) begin
						rx_st_q  <= RX_DATA;
						rx_cnt_q <= 4'd8;
					end else if (!m0 && rx_fall) begin
						rx_st_q <= RX_START;
					end
				end
				RX_START: begin
					rx_tmr_q <= rx_tmr_q + 12'h001;
					if (rx_tmr_q >= half) begin
						rx_tmr_q <= 12'h000;
						// A start bit that is high again was a glitch
						rx_st_q  <= RXD_I ? RX_IDLE : RX_DATA;
						rx_cnt_q <= nine ? 4'd9 : 4'd8;
					end
				end
				RX_DATA: begin
					rx_tmr_q <= rx_tmr_q + 12'h001;
					if (rx_tmr_q >= div - 12'h001) begin
						rx_tmr_q <= 12'h000;
						rx_cnt_q <= rx_cnt_q - 4'h1;
						// Async data is sampled at bit centres, one full cell apart
						if (m0 || !nine)
							rx_sh_q <= {1'b0, RXD_I, rx_sh_q[7:1]};
						else
							rx_sh_q <= {RXD_I, rx_sh_q[8:1]};
						if (rx_cnt_q == 4'h1) begin
							if (m0) begin
								rx_buf_q <= {RXD_I, rx_sh_q[7:1]};
								rx_set   <= 1'b1;
								rx_st_q  <= RX_IDLE;
							end else begin
								rx_st_q <= RX_STOP;
							end
						end
					end
				end
				RX_STOP: begin
					rx_tmr_q <= rx_tmr_q + 12'h001;
					// Centre of the stop bit is halfway through its time
					if (rx_tmr_q >= div - 12'h001) begin
						rx_st_q <= RX_IDLE;
						fe_set  <= ~RXD_I;
						if (nine) begin
							if (!ctl_q[`CTL_FILTER] || (rx_sh_q[8] && addr_ok)) begin
								rx_buf_q <= rx_sh_q[7:0];
								rx_ninth <= rx_sh_q[8];
								rx_set   <= 1'b1;
							end
						end else if (!ctl_q[`CTL_FILTER] || RXD_I) begin
							rx_buf_q <= rx_sh_q[7:0];
							rx_ninth <= RXD_I;
							rx_set   <= 1'b1;
						end
					end
				end
				default: rx_st_q <= RX_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes; hardware set beats software clear
	// A control write and a flag event in one cycle keep the flag,
	// so software never loses an event it has not yet seen
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			ctl_q     <= `RST_BYTE;
			tx_buf_q  <= `RST_BYTE;
			own_slave_address_q   <= `RST_BYTE;
			mask_q    <= `RST_BYTE;
			pwr_q     <= `RST_BYTE;
			fe_q      <= 1'b0;
			mode_hi_q <= 1'b0;
		end else if (CE_I) begin
			if (wr_ctl) begin
				ctl_q <= DAT_I[7:0];
				if (fe_sel)
					fe_q <= DAT_I[`CTL_MODE_HI];
				else
					mode_hi_q <= DAT_I[`CTL_MODE_HI];
			end
			if (wr_buf) tx_buf_q <= DAT_I[7:0];
			if (wr & hit_sa) own_slave_address_q <= DAT_I[7:0];
			if (wr & hit_msk) mask_q <= DAT_I[7:0];
			if (wr & hit_pwr) pwr_q <= DAT_I[7:0];
			if (fe_set) fe_q <= 1'b1;
			if (tx_set) ctl_q[`CTL_TX_DONE] <= 1'b1;
			if (rx_set) ctl_q[`CTL_RX_DONE] <= 1'b1;
			if (rx_set) ctl_q[`CTL_RX9] <= m0 ? ctl_q[`CTL_RX9] : rx_ninth;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux, acknowledge, outputs
	// Reads have no side effects: flags clear only by an explicit write
	reg [7:0] rd;
	always @* begin
		rd = 8'h00;
		if (hit_ctl) rd = {fe_sel ? fe_q : mode_hi_q, ctl_q[6:0]};
		if (hit_buf) rd = rx_buf_q;
		if (hit_sa)  rd = own_slave_address_q;
		if (hit_msk) rd = mask_q;
		if (hit_pwr) rd = pwr_q;
	end

	// Every output is registered; the line and request lag state by one clock
	// One wait-free answer; unmapped addresses get an error
	always @(posedge CLK_I) begin
		if (SRST_I) begin
			DAT_O      <= 32'h0000_0000;
			ACK_O      <= 1'b0;
			ERR_O      <= 1'b0;
			TXD_O      <= 1'b1;
			RXD_O      <= 1'b1;
			RXD_OE_N_O <= 1'b1;
			IRQ_O      <= 1'b0;
		end else if (CE_I) begin
			ACK_O <= req & mapped;
			ERR_O <= req & ~mapped;
			DAT_O <= {24'h000000, rd};
			IRQ_O <= ctl_q[`CTL_TX_DONE] | ctl_q[`CTL_RX_DONE];
			// Mode 0: data on the bidirectional line, shift clock on TXD
			if (m0 && tx_st_q == TX_SEND) begin
				RXD_O      <= tx_sh_q[0];
				RXD_OE_N_O <= 1'b0;
				TXD_O      <= ~tx_tick;
			end else if (m0 && rx_st_q == RX_DATA) begin
				// Mode 0 receive also drives the shift clock, one low per bit
				RXD_O      <= 1'b1;
				RXD_OE_N_O <= 1'b1;
				TXD_O      <= (rx_tmr_q != div - 12'h001);
			end else begin
				RXD_O      <= 1'b1;
				RXD_OE_N_O <= 1'b1;
				TXD_O      <= m0 ? 1'b1 : tx_sh_q[0];
			end
		end
	end
endmodule

// >>> bench/serial_port_zero_checker.sv
`timescale 1ns/100ps
// Port-level checks; the bus answer rules are what software leans on
module serial_port_zero_checker (
	// System
	input wire        CLK_I,
	input wire        SRST_I,
	input wire        CE_I,
	// Bus
	input wire        CYC_I,
	input wire        STB_I,
	input wire [31:0] DAT_O,
	input wire        ACK_O,
	input wire        ERR_O,
	// Line and request
	input wire        TXD_O,
	input wire        IRQ_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	////////////////////////////////////////
	// A taken request is answered once, one cycle later
	property p_answer; CYC_I && STB_I && CE_I && !ACK_O && !ERR_O |=> ACK_O != ERR_O; endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_ack_one; ACK_O |=> !ACK_O; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_err_one; ERR_O |=> !ERR_O; endproperty
	a_err_one: assert property (p_err_one) else $error("err too long");
	property p_cause; ACK_O || ERR_O |-> $past(CYC_I && STB_I); endproperty
	a_cause: assert property (p_cause) else $error("answer without request");
	property p_excl; ERR_O |-> !ACK_O; endproperty
	a_excl: assert property (p_excl) else $error("ack with err");
	// Registers are one byte wide, upper lanes read zero
	property p_byte; ACK_O |-> DAT_O[31:8] == 24'h0; endproperty
	a_byte: assert property (p_byte) else $error("upper read data");
	// Reset leaves the line idle and no request pending
	property p_reset; disable iff (1'h0) SRST_I && CE_I |=> TXD_O && !IRQ_O && !ACK_O; endproperty
	a_reset: assert property (p_reset) else $error("reset state");
	property p_freeze; !CE_I |=> $stable(TXD_O) && $stable(IRQ_O); endproperty
	a_freeze: assert property (p_freeze) else $error("moved while frozen");
endmodule

bind serial_port_zero serial_port_zero_checker u_checker (
	.CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I), .CYC_I(CYC_I), .STB_I(STB_I),
	.DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O), .TXD_O(TXD_O), .IRQ_O(IRQ_O)
);

// >>> bench/serial_node.sv
`timescale 1ns/100ps
// Far node on the line; drives the line high while at rest
module serial_node (
	input  wire        clk_i,
	input  wire        txd_i,
	input  wire [11:0] div_i,
	output reg         rxd_o
);
	initial rxd_o = 1'h1;
	////////////////////////////////////////
	// Whole clock counts per bit keep edges clean for the port
	task automatic send(input [8:0] d, input integer n, input stop);
		integer i;
		begin
			@(posedge clk_i) rxd_o <= 1'h0;
			for (i = 0; i <= n; i = i + 1) begin
				repeat (div_i) @(posedge clk_i);
				rxd_o <= (i == n) ? stop : d[i];
			end
			repeat (div_i) @(posedge clk_i);
			rxd_o <= 1'h1;
		end
	endtask
	// Mid-bit sampling after a bounded wait for the start bit
	task automatic take(input integer n, output [9:0] d, output ok);
		integer i;
		begin
			d = 10'h0;
			ok = 1'h0;
			for (i = 0; i < 30 * div_i && !ok; i = i + 1) @(posedge clk_i) ok = !txd_i;
			repeat (div_i / 2) @(posedge clk_i);
			for (i = 0; i < n; i = i + 1) begin
				repeat (div_i) @(posedge clk_i);
				d[i] = txd_i;
			end
		end
	endtask
endmodule

// >>> bench/test_serial_port_zero.sv
`timescale 1ns/100ps
`include "serial_port_zero_regs.vh"
module test_serial_port_zero;
	logic        clk = 1'h0, rst = 1'h1, ce = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
	logic        ack, err, e, rx_pin, rx_out, oe_n, txd, irq, node_tx, ok;
	logic [9:0]  adr = 10'h0, v;
	logic [31:0] wdat = 32'h0, rdat, q, p;
	logic [11:0] rate = 12'h008;
	logic [7:0]  d, c, tab [5];
	integer      miscompares = 0, total_checks = 0, seed = 32'hf57c509c, i, n;
	// Line level from the node and the port's own mode 0 driver
	assign rx_pin = oe_n ? node_tx : rx_out;
	serial_port_zero u_serial_port_zero (
		.CLK_I(clk), .SRST_I(rst), .CE_I(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(4'hf), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .ERR_O(err),
		.RATE_DIV_I(rate), .RXD_I(rx_pin), .RXD_O(rx_out), .RXD_OE_N_O(oe_n),
		.TXD_O(txd), .IRQ_O(irq)
	);
	serial_node u_serial_node (.clk_i(clk), .txd_i(txd), .div_i(rate), .rxd_o(node_tx));
	initial forever #4 clk = ~clk;
	////////////////////////////////////////
	task end_of_test;
		begin
			if (miscompares == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task automatic chk(input [31:0] seen, input [31:0] exp, input string what);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("[ERR] %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	// One classic cycle, held until the answer edge
	task automatic bus(input w, input [7:0] idx, input [7:0] b);
		integer n;
		begin
			@(posedge clk);
			{cyc, stb, we, adr, wdat} <= {2'h3, w, idx, 2'h0, 24'h0, b};
			for (n = 0; n < 40 && ack !== 1'h1 && err !== 1'h1; n = n + 1) @(posedge clk);
			q = rdat;
			e = err;
			{cyc, stb} <= 2'h0;
			if (n >= 40) begin
				chk(n, 0, "bus answer");
				end_of_test;
			end
		end
	endtask
	// Mode 0 shift clock period follows the filter bit
	function automatic [31:0] m0_period(input f);
		m0_period = f ? 32'h4 : 32'hc;
	endfunction
	////////////////////////////////////////
	initial begin
		tab = '{`IDX_PORT_CONTROL, `IDX_PORT_DATA_BUFFER, `IDX_OWN_SLAVE_ADDR,
			`IDX_ADDRESS_MASK, `IDX_POWER_CONTROL};
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		for (i = 0; i < 5; i = i + 1) begin
			bus(0, tab[i], 8'h0);
			chk(q, 32'h0, "reset value");
		end
		bus(0, 8'h00, 8'h0);
		chk(e, 1'h1, "unmapped");
		d = 8'($random(seed));
		bus(1, `IDX_OWN_SLAVE_ADDR, d);
		bus(0, `IDX_OWN_SLAVE_ADDR, 8'h0);
		chk(q, {24'h0, d}, "slave address");
		ce <= 1'h0;
		repeat (3) @(posedge clk);
		ce <= 1'h1;
		// Transmit in modes 1 and 3, ninth bit both ways
		for (i = 0; i < 4; i = i + 1) begin
			c = {i[1], 3'h5, i[0], 3'h0};
			d = 8'($random(seed));
			bus(1, `IDX_PORT_CONTROL, c);
			fork
				u_serial_node.take(i[1] ? 10 : 9, v, ok);
				bus(1, `IDX_PORT_DATA_BUFFER, d);
			join
			chk({ok, v}, {1'h1, i[1] ? {1'h1, i[0]} : 2'h1, d}, "frame");
			bus(0, `IDX_PORT_CONTROL, 8'h0);
			chk(q, {24'h0, c | 8'h02}, "tx done");
			chk(irq, 1'h1, "irq set");
		end
		bus(1, `IDX_PORT_CONTROL, 8'hf0);
		repeat (2) @(posedge clk);
		chk(irq, 1'h0, "irq clear");
		// Mode 3 with the filter: only a set ninth bit is taken
		for (i = 0; i < 2; i = i + 1) begin
			d = 8'($random(seed));
			u_serial_node.send({i[0], d}, 9, 1'h1);
			bus(0, `IDX_PORT_CONTROL, 8'h0);
			chk(q[0], i[0], "filtered done");
			if (i[0]) chk(q[2], 1'h1, "ninth");
		end
		bus(0, `IDX_PORT_DATA_BUFFER, 8'h0);
		chk(q, {24'h0, d}, "rx data");
		// Mode 0 at both rates with reception off
		for (i = 0; i < 2; i = i + 1) begin
			c = {2'h0, i[0], 5'h0};
			bus(1, `IDX_PORT_CONTROL, c);
			bus(1, `IDX_PORT_DATA_BUFFER, 8'($random(seed)));
			for (n = 0; n < 99 && txd !== 1'h0; n = n + 1) @(posedge clk);
			for (p = 0; p < 99 && txd !== 1'h1; p = p + 1) @(posedge clk);
			for (p = p; p < 99 && txd !== 1'h0; p = p + 1) @(posedge clk);
			chk(p, m0_period(i[0]), "shift period");
			chk(oe_n, 1'h0, "mode 0 drive");
			q = 32'h0;
			for (n = 0; n < 99 && q[1] !== 1'h1; n = n + 0) begin
				bus(0, `IDX_PORT_CONTROL, 8'h0);
				n = n + 1;
			end
			chk(q, {24'h0, c | 8'h02}, "mode 0 done");
			chk(oe_n, 1'h1, "line released");
		end
		// Mode 1 receive: good frame, disabled, bad stop under filter
		bus(1, `IDX_POWER_CONTROL, 8'h40);
		for (i = 0; i < 3; i = i + 1) begin
			bus(1, `IDX_PORT_CONTROL, {2'h1, i == 2, i != 1, 4'h0});
			d = 8'($random(seed));
			u_serial_node.send({1'h0, d}, 8, i != 2);
			bus(0, `IDX_PORT_CONTROL, 8'h0);
			chk({q[7], q[0]}, {i == 2, i == 0}, "mode 1 flags");
			if (i == 0) chk(q[2], 1'h1, "stop capture");
		end
		end_of_test;
	end
endmodule
